// *** rtl/qsh_map.vh ***
// register selectors, field positions and reset values of the questionable status block
`ifndef QSH_MAP_VH
`define QSH_MAP_VH
`define QSH_SEL_QUESTIONABLE_GROUP_EVENT 4'h0
`define QSH_SEL_QUESTIONABLE_GROUP_ENABLE 4'h1
`define QSH_SEL_INST_EVENT 4'h2
`define QSH_SEL_INST_ENABLE 4'h3
`define QSH_SEL_SUM1_EVENT 4'h4
`define QSH_SEL_SUM1_ENABLE 4'h5
`define QSH_SEL_SUM2_EVENT 4'h6
`define QSH_SEL_SUM2_ENABLE 4'h7
`define QSH_SEL_SUM1_COND 4'h8
`define QSH_SEL_SUM2_COND 4'h9
`define QSH_SEL_SUMMARY 4'hA
`define QSH_SEL_REMOTE 4'hB
`define QSH_QUESTIONABLE_GROUP_FAN_BIT 4
`define QSH_PER_OUTPUT_FAULT_GROUP_BIT 13
`define QSH_INST_OUT1_BIT 1
`define QSH_INST_OUT2_BIT 2
`define QSH_SUM_VOLT_BIT 0
`define QSH_SUM_CURR_BIT 1
`define QSH_SUM_OVP_BIT 9
`define QSH_COND_CC_BIT 0
`define QSH_COND_CV_BIT 1
`define QSH_TOP_QUESTIONABLE_GROUP_BIT 3
`define QSH_ENABLE_RESET 16'h0000
`define QSH_IF_BUS 1'b0
`define QSH_IF_SERIAL 1'b1
`define QSH_MODE_LOCAL 2'h0
`define QSH_MODE_REMOTE 2'h1
`define QSH_MODE_LOCKOUT 2'h2
`endif

// *** rtl/qsh_status.v ***
// questionable status hierarchy, remote interface select and front-panel mode control
//
// Function
// R1: event bits latch until explicitly cleared
// R2: query read or clear-status clears event register
// R3: reset or device-clear leaves events unchanged
// R4: event read returns register as unsigned integer
// R5: summary is OR of enabled event bits
// R6: enable masks read and write, reads harmless
// R7: clear-status leaves enable masks unchanged
// R8: instrument summary drives questionable bit 13
// R9: fan fault sets bit 4, others zero
// R10: output1 sets bit 1, output2 bit 2
// R11: per-output voltage bit 0, current bit 1
// R12: overvoltage trip sets per-output bit 9
// R13: condition view encodes CV, CC, unregulated, off
// R14: host writes masks 6 and 515
// R15: questionable enable cleared only by writing zero
// R16: one remote interface, instrument bus default
// R17: local all keys, remote only local key
// R18: lockout disables every key including local
// R19: serial control-C aborts and discards output
// R20: host enters serial remote before serial traffic
// R21: top summary collects group summaries only
// R22: questionable summary is top bit 3
// R23: summaries combinational, clear in same cycle
`include "qsh_map.vh"
`timescale 1ns/1ps
`default_nettype none
module qsh_status (
	input wire core_clk_i,
	input wire rstn_i,
	input wire fan_fault_i,
	input wire [1:0] volt_unreg_i,
	input wire [1:0] curr_unreg_i,
	input wire [1:0] ovp_trip_i,
	input wire [1:0] cv_active_i,
	input wire [1:0] cc_active_i,
	input wire [1:0] output_on_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [3:0] reg_sel_i,
	input wire [15:0] reg_wdata_i,
	output reg [15:0] reg_rdata_o,
	input wire clear_status_command_i,
	input wire reset_command_i,
	input wire device_clear_i,
	input wire if_select_wr_i,
	input wire if_select_i,
	input wire sys_local_i,
	input wire sys_remote_i,
	input wire remote_full_lockout_i,
	input wire serial_rx_valid_i,
	input wire [7:0] serial_rx_data_i,
	input wire [15:0] key_press_i,
	input wire [3:0] local_key_idx_i,
	output wire [15:0] key_enabled_o,
	output wire bus_enable_o,
	output wire serial_enable_o,
	output wire [1:0] panel_mode_o,
	output reg abort_o,
	output reg discard_output_o,
	output wire [7:0] status_summary_o
);
	localparam [7:0] CTRL_C = 8'h03;
	localparam [15:0] SUM_DEFINED = 16'h0203;
	wire [15:0] questionable_group_ev;
	wire [15:0] questionable_group_en;
	wire [15:0] inst_ev;
	wire [15:0] inst_en;
	wire [15:0] sum1_ev;
	wire [15:0] sum1_en;
	wire [15:0] sum2_ev;
	wire [15:0] sum2_en;
	reg if_sel_r;
	reg [1:0] mode_r;
	reg [15:0] sum_cond [0:1];
	wire [1:0] out_sum;
	wire inst_summary;
	wire questionable_group_summary;
	reg [15:0] sum_set [0:1];
	reg [15:0] inst_set;
	reg [15:0] questionable_group_set;
	wire rd_questionable_group = reg_rd_i && (reg_sel_i == `QSH_SEL_QUESTIONABLE_GROUP_EVENT);
	wire rd_inst = reg_rd_i && (reg_sel_i == `QSH_SEL_INST_EVENT);
	wire rd_sum1 = reg_rd_i && (reg_sel_i == `QSH_SEL_SUM1_EVENT);
	wire rd_sum2 = reg_rd_i && (reg_sel_i == `QSH_SEL_SUM2_EVENT);
	wire serial_abort = serial_rx_valid_i && (serial_rx_data_i == CTRL_C) &&
		(if_sel_r == `QSH_IF_SERIAL); // see R19
	integer i;

	// per-output condition view and summaries
	always @* begin
		for (i = 0; i < 2; i = i + 1) begin
			sum_cond[i] = 16'h0000;
			// both set when unregulated, neither when off
			sum_cond[i][`QSH_COND_CV_BIT] = output_on_i[i] &
				(cv_active_i[i] | (volt_unreg_i[i] & curr_unreg_i[i])); // see R13
			sum_cond[i][`QSH_COND_CC_BIT] = output_on_i[i] &
				(cc_active_i[i] | (volt_unreg_i[i] & curr_unreg_i[i])); // see R13
			sum_set[i] = 16'h0000;
			sum_set[i][`QSH_SUM_VOLT_BIT] = volt_unreg_i[i]; // see R11
			sum_set[i][`QSH_SUM_CURR_BIT] = curr_unreg_i[i]; // see R11
			sum_set[i][`QSH_SUM_OVP_BIT] = ovp_trip_i[i]; // see R12
		end
		inst_set = 16'h0000;
		inst_set[`QSH_INST_OUT1_BIT] = out_sum[0]; // see R10 R8
		inst_set[`QSH_INST_OUT2_BIT] = out_sum[1]; // see R10 R8
		questionable_group_set = 16'h0000;
		questionable_group_set[`QSH_QUESTIONABLE_GROUP_FAN_BIT] = fan_fault_i; // see R9
		questionable_group_set[`QSH_PER_OUTPUT_FAULT_GROUP_BIT] = inst_summary; // see R8
	end

	// top summary holds only group summaries
	assign status_summary_o = {4'h0, questionable_group_summary, 3'h0}; // see R21 R22

	// four event groups; reset command and device-clear never reach a clear, see R3
	qsh_event_group #(
		.WIDTH(16)
	) u_questionable_group (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.set_i(questionable_group_set), // see R9
		.clear_i(rd_questionable_group || clear_status_command_i), // see R2
		.en_wr_i(reg_wr_i && (reg_sel_i == `QSH_SEL_QUESTIONABLE_GROUP_ENABLE)), // see R15
		.en_wdata_i(reg_wdata_i),
		.event_o(questionable_group_ev),
		.enable_o(questionable_group_en),
		.summary_o(questionable_group_summary) // see R22
	);

	qsh_event_group #(
		.WIDTH(16)
	) u_inst (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.set_i(inst_set), // see R10
		.clear_i(rd_inst || clear_status_command_i), // see R2
		.en_wr_i(reg_wr_i && (reg_sel_i == `QSH_SEL_INST_ENABLE)), // see R6 R14
		.en_wdata_i(reg_wdata_i),
		.event_o(inst_ev),
		.enable_o(inst_en),
		.summary_o(inst_summary) // see R8
	);

	qsh_event_group #(
		.WIDTH(16)
	) u_sum1 (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.set_i(sum_set[0]), // see R11 R12
		.clear_i(rd_sum1 || clear_status_command_i), // see R2
		.en_wr_i(reg_wr_i && (reg_sel_i == `QSH_SEL_SUM1_ENABLE)), // see R6 R14
		.en_wdata_i(reg_wdata_i),
		.event_o(sum1_ev),
		.enable_o(sum1_en),
		.summary_o(out_sum[0])
	);

	qsh_event_group #(
		.WIDTH(16)
	) u_sum2 (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.set_i(sum_set[1]), // see R11 R12
		.clear_i(rd_sum2 || clear_status_command_i), // see R2
		.en_wr_i(reg_wr_i && (reg_sel_i == `QSH_SEL_SUM2_ENABLE)), // see R6 R14
		.en_wdata_i(reg_wdata_i),
		.event_o(sum2_ev),
		.enable_o(sum2_en),
		.summary_o(out_sum[1])
	);

	// read data registered one cycle after the read strobe
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_sel_i)
				`QSH_SEL_QUESTIONABLE_GROUP_EVENT: reg_rdata_o <= questionable_group_ev; // see R4 R9
				`QSH_SEL_QUESTIONABLE_GROUP_ENABLE: reg_rdata_o <= questionable_group_en; // see R6
				`QSH_SEL_INST_EVENT: reg_rdata_o <= inst_ev; // see R4
				`QSH_SEL_INST_ENABLE: reg_rdata_o <= inst_en; // see R6
				`QSH_SEL_SUM1_EVENT: reg_rdata_o <= sum1_ev; // see R4
				`QSH_SEL_SUM1_ENABLE: reg_rdata_o <= sum1_en; // see R6
				`QSH_SEL_SUM2_EVENT: reg_rdata_o <= sum2_ev; // see R4
				`QSH_SEL_SUM2_ENABLE: reg_rdata_o <= sum2_en; // see R6
				`QSH_SEL_SUM1_COND: reg_rdata_o <= sum_cond[0]; // see R13
				`QSH_SEL_SUM2_COND: reg_rdata_o <= sum_cond[1]; // see R13
				`QSH_SEL_SUMMARY: reg_rdata_o <= {8'h00, status_summary_o};
				`QSH_SEL_REMOTE: reg_rdata_o <= {13'h0000, if_sel_r, mode_r};
				default: reg_rdata_o <= 16'h0000;
			endcase
		end
	end

	// interface select and panel mode
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			if_sel_r <= `QSH_IF_BUS; // see R16
			mode_r <= `QSH_MODE_LOCAL;
		end else begin
			if (if_select_wr_i) begin
				if_sel_r <= if_select_i; // see R16
			end
			case (mode_r)
				`QSH_MODE_LOCAL: begin
					if (remote_full_lockout_i) begin
						mode_r <= `QSH_MODE_LOCKOUT; // see R18
					end else if (sys_remote_i) begin
						mode_r <= `QSH_MODE_REMOTE;
					end
				end
				`QSH_MODE_REMOTE: begin
					if (sys_local_i) begin
						mode_r <= `QSH_MODE_LOCAL;
					end else if (remote_full_lockout_i) begin
						mode_r <= `QSH_MODE_LOCKOUT; // see R18
					end else if (key_press_i[local_key_idx_i]) begin
						mode_r <= `QSH_MODE_LOCAL; // see R17
					end
				end
				`QSH_MODE_LOCKOUT: begin
					if (sys_local_i) begin
						mode_r <= `QSH_MODE_LOCAL;
					end else if (sys_remote_i) begin
						mode_r <= `QSH_MODE_REMOTE;
					end
				end
				default: mode_r <= `QSH_MODE_LOCAL;
			endcase
		end
	end

	assign bus_enable_o = (if_sel_r == `QSH_IF_BUS); // see R16
	assign serial_enable_o = (if_sel_r == `QSH_IF_SERIAL); // see R16
	assign panel_mode_o = mode_r;
	assign key_enabled_o = (mode_r == `QSH_MODE_LOCAL) ? 16'hFFFF :
		(mode_r == `QSH_MODE_REMOTE) ? (16'h0001 << local_key_idx_i) :
		16'h0000; // see R17 R18

	// abort pulses on control-C while the serial interface is selected, or on device-clear; a reset command does not abort
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			abort_o <= 1'b0;
			discard_output_o <= 1'b0;
		end else begin
			abort_o <= serial_abort || device_clear_i; // see R19
			discard_output_o <= serial_abort || device_clear_i; // see R19
		end
	end
endmodule

// one event register with its enable mask and its summary bit
module qsh_event_group #(
	parameter WIDTH = 16
) (
	input wire core_clk_i,
	input wire rstn_i,
	input wire [WIDTH-1:0] set_i,
	input wire clear_i,
	input wire en_wr_i,
	input wire [WIDTH-1:0] en_wdata_i,
	output reg [WIDTH-1:0] event_o,
	output reg [WIDTH-1:0] enable_o,
	output wire summary_o
);
	// a set in the clearing cycle survives, so no event is lost to a query
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			event_o <= {WIDTH{1'b0}};
		end else begin
			event_o <= (clear_i ? {WIDTH{1'b0}} : event_o) | set_i; // see R1 R2
		end
	end

	// only a write changes the mask; reads and clear-status leave it alone
	always @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			enable_o <= `QSH_ENABLE_RESET;
		end else if (en_wr_i) begin
			enable_o <= en_wdata_i; // see R6 R7 R15
		end
	end

	// not latched, so a cleared event drops its summary at once
	assign summary_o = |(event_o & enable_o); // see R5 R21 R23
endmodule
`default_nettype wire

// *** verif/qsh_status_monitor.sv ***
// port assertions for the questionable status block
`timescale 1ns/1ps
`default_nettype none
module qsh_status_monitor (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic reg_rd_i,
	input wire logic [3:0] reg_sel_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic device_clear_i,
	input wire logic serial_rx_valid_i,
	input wire logic [7:0] serial_rx_data_i,
	input wire logic [3:0] local_key_idx_i,
	input wire logic [15:0] key_enabled_o,
	input wire logic bus_enable_o,
	input wire logic serial_enable_o,
	input wire logic [1:0] panel_mode_o,
	input wire logic abort_o,
	input wire logic discard_output_o,
	input wire logic [7:0] status_summary_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	a_questionable_group_unused_zero: assert property (reg_rd_i && reg_sel_i == 4'h0 |=>
		(reg_rdata_o & 16'hDFEF) == 16'h0000) else $error("unused bit set");
	a_top_only_bit3: assert property (status_summary_o[7:4] == 4'h0 &&
		status_summary_o[2:0] == 3'h0) else $error("top summary stray bit");
	a_iface_one_hot: assert property (bus_enable_o != serial_enable_o)
		else $error("interface enables not one-hot");
	a_local_all_keys: assert property (panel_mode_o == 2'h0 |-> key_enabled_o == 16'hFFFF)
		else $error("local keys blocked");
	a_remote_local_key: assert property (panel_mode_o == 2'h1 |->
		key_enabled_o == (16'h0001 << local_key_idx_i)) else $error("remote key mask");
	a_lockout_no_keys: assert property (panel_mode_o == 2'h2 |-> key_enabled_o == 16'h0000)
		else $error("lockout key enabled");
	a_ctrlc_abort: assert property (serial_rx_valid_i && serial_rx_data_i == 8'h03 &&
		serial_enable_o |=> abort_o && discard_output_o) else $error("no serial abort");
	a_devclr_abort: assert property (device_clear_i |=> abort_o && discard_output_o)
		else $error("no clear abort");
	a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved");
	c_lockout: cover property (panel_mode_o == 2'h2);
	c_ctrlc: cover property (serial_enable_o && serial_rx_valid_i);
	c_qsum: cover property (status_summary_o[3]);
endmodule
bind qsh_status qsh_status_monitor mon (.core_clk_i, .rstn_i, .reg_rd_i, .reg_sel_i,
	.reg_rdata_o, .device_clear_i, .serial_rx_valid_i, .serial_rx_data_i, .local_key_idx_i,
	.key_enabled_o, .bus_enable_o, .serial_enable_o, .panel_mode_o, .abort_o,
	.discard_output_o, .status_summary_o);
`default_nettype wire

// *** verif/qsh_host_model.sv ***
// host controller model: one strobed register access at a time
`timescale 1ns/1ps
`default_nettype none
module qsh_host_model (
	input wire logic clk_i,
	output logic wr_o,
	output logic rd_o,
	output logic [3:0] sel_o,
	output logic [15:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		sel_o = 4'hF;
		wdata_o = 16'h0000;
	end
	task automatic acc(input logic w, input logic [3:0] s, input logic [15:0] d);
		@(posedge clk_i) #1;
		wr_o = w;
		rd_o = !w;
		sel_o = s;
		wdata_o = d;
		@(posedge clk_i) #1;
		wr_o = 1'b0;
		rd_o = 1'b0;
		// released lines do not keep the last value
		sel_o = ~s;
		wdata_o = ~d;
	endtask
endmodule
`default_nettype wire

// *** verif/tb_questionable_status_hierarchy.sv ***
// self-checking bench for the questionable status block
`timescale 1ns/1ps
`default_nettype none
module tb_questionable_status_hierarchy;
	logic clk = 1'b0, rstn = 1'b0, fan = 1'b0, clr = 1'b0, rcmd = 1'b0, dclr = 1'b0;
	logic ifw = 1'b0, ifs = 1'b0, loc = 1'b0, rem = 1'b0, lck = 1'b0, rxv = 1'b0;
	logic [1:0] vu = 2'h0, cu = 2'h0, overvoltage_trip = 2'h0, cv = 2'h0, cc = 2'h0, pon = 2'h3;
	logic [7:0] rxd = 8'h00, summ;
	logic [3:0] sel;
	logic [15:0] wd, rdata, keys, kp = 16'h0000;
	logic [1:0] pm;
	logic wr, rd, rd_d = 1'b0, bus_en, ser_en, ab, disc;
	logic [15:0] exp_q[$];
	int err_count = 0, cmp_count = 0, cyc = 0, m;
	always #2 clk = ~clk;
	qsh_host_model host (.clk_i(clk), .wr_o(wr), .rd_o(rd), .sel_o(sel), .wdata_o(wd));
	qsh_status dut (.core_clk_i(clk), .rstn_i(rstn), .fan_fault_i(fan), .volt_unreg_i(vu),
		.curr_unreg_i(cu), .ovp_trip_i(overvoltage_trip), .cv_active_i(cv), .cc_active_i(cc),
		.output_on_i(pon), .reg_wr_i(wr), .reg_rd_i(rd), .reg_sel_i(sel), .reg_wdata_i(wd),
		.reg_rdata_o(rdata), .clear_status_command_i(clr), .reset_command_i(rcmd),
		.device_clear_i(dclr), .if_select_wr_i(ifw), .if_select_i(ifs), .sys_local_i(loc),
		.sys_remote_i(rem), .remote_full_lockout_i(lck), .serial_rx_valid_i(rxv),
		.serial_rx_data_i(rxd), .key_press_i(kp), .local_key_idx_i(4'h5),
		.key_enabled_o(keys), .bus_enable_o(bus_en), .serial_enable_o(ser_en),
		.panel_mode_o(pm), .abort_o(ab), .discard_output_o(disc), .status_summary_o(summ));
	task automatic step;
		@(posedge clk) #1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdx(input logic [3:0] s, input logic [15:0] e);
		exp_q.push_back(e);
		host.acc(1'b0, s, 16'h0000);
	endtask
	task automatic tally_and_finish;
		$display("counts cmp=%0d err=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		rd_d <= rd;
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			tally_and_finish;
		end
	end
	// read data lands one edge after the strobe
	always @(negedge clk)
		if (rd_d)
			chk(rdata, exp_q.pop_front());
	initial begin
		m = $urandom(32'h48f13b25);
		repeat (6) @(posedge clk);
		#1 rstn = 1'b1;
		host.acc(1'b1, 4'h3, 16'h0006);
		host.acc(1'b1, 4'h5, 16'h0203);
		host.acc(1'b1, 4'h7, 16'h0203);
		host.acc(1'b1, 4'h1, 16'h2010);
		rdx(4'h5, 16'h0203);
		rdx(4'h1, 16'h2010);
		rdx(4'h1, 16'h2010);
		$display("test masks done");
		step;
		fan = 1'b1;
		step;
		fan = 1'b0;
		step;
		chk(summ, 8'h08);
		rdx(4'h0, 16'h0010);
		rdx(4'h0, 16'h0000);
		vu = 2'b01;
		step;
		vu = 2'b00;
		repeat (3) step;
		rdx(4'h4, 16'h0001);
		rdx(4'h2, 16'h0002);
		rdx(4'h0, 16'h2000);
		overvoltage_trip = 2'b10;
		cu = 2'b10;
		step;
		overvoltage_trip = 2'b00;
		cu = 2'b00;
		dclr = 1'b1;
		rcmd = 1'b1;
		step;
		dclr = 1'b0;
		rcmd = 1'b0;
		chk(ab, 1'b1);
		rdx(4'h6, 16'h0202);
		clr = 1'b1;
		repeat (3) step;
		clr = 1'b0;
		chk(summ, 8'h00);
		rdx(4'h6, 16'h0000);
		rdx(4'h0, 16'h0000);
		rdx(4'h7, 16'h0203);
		rdx(4'h1, 16'h2010);
		$display("test events done");
		repeat (6) begin
			m = $urandom % 3;
			pon = {1'b0, m != 0};
			cv = {1'b0, m == 1};
			cc = {1'b0, m == 2};
			rdx(4'h8, {14'h0000, m == 1, m == 2});
		end
		$display("test cond done");
		chk(bus_en, 1'b1);
		ifs = 1'b1;
		ifw = 1'b1;
		step;
		ifw = 1'b0;
		step;
		chk({bus_en, ser_en}, 2'b01);
		rem = 1'b1;
		step;
		rem = 1'b0;
		chk(keys, 16'h0020);
		rxd = 8'h03;
		rxv = 1'b1;
		step;
		rxv = 1'b0;
		chk({ab, disc}, 2'b11);
		lck = 1'b1;
		step;
		lck = 1'b0;
		chk(keys, 16'h0000);
		chk(pm, 2'h2);
		rdx(4'hB, 16'h0006);
		loc = 1'b1;
		step;
		loc = 1'b0;
		chk(keys, 16'hFFFF);
		rem = 1'b1;
		step;
		rem = 1'b0;
		kp = 16'h0020;
		step;
		kp = 16'h0000;
		chk(keys, 16'hFFFF);
		$display("test modes done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
